// File: src/wdt_params.svh
// Purpose: Constants for the two-stage watchdog timer
// Assumes: 8-bit word-aligned register addresses, 32-bit data
// Notes: Definitions only
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

`define WDT_ADDR_W     8
`define WDT_DATA_W     32
`define WDT_CTRL_W     4

`define WDT_OFS_LOAD   8'h00
`define WDT_OFS_VALUE  8'h04
`define WDT_OFS_CTRL   8'h08
`define WDT_OFS_ICR    8'h0c
`define WDT_OFS_RIS    8'h10
`define WDT_OFS_MIS    8'h14
`define WDT_OFS_LOCK   8'h18

`define WDT_LOAD_RST   32'hffffffff
`define WDT_ZERO       32'h00000000
// Key value is arbitrary
`define WDT_UNLOCK_KEY 32'h5a5ac0de

`endif

// File: src/wdt_pkg.sv
// Purpose: Types shared by the watchdog files
// Assumes: wdt_params.svh for widths
// Notes: Control layout is the low bits of the control word
`include "wdt_params.svh"

package wdt_pkg;

	typedef struct packed {
		logic                     wr;
		logic                     rd;
		logic [`WDT_ADDR_W-1:0]   addr;
		logic [`WDT_DATA_W-1:0]   wdata;
	} wdt_bus_req_t;

	typedef struct packed {
		logic stallEn;
		logic resetEn;
		logic intEn;
		logic enable;
	} wdt_ctrl_t;

	typedef enum logic [1:0] {
		WDT_IDLE = 2'b00,
		WDT_RUN  = 2'b01,
		WDT_RST  = 2'b10
	} wdt_stage_t;

endpackage

// File: src/wdt_counter.sv
// Purpose: 32-bit down counter with synchronous load
// Assumes: Load has priority over decrement
// Notes: Stops at zero; the owner reloads it
`timescale 1ns/1ps
`include "wdt_params.svh"

module wdt_counter (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	// Control
	input  wire logic                   load,
	input  wire logic [`WDT_DATA_W-1:0] loadVal,
	input  wire logic                   dec,
	// State
	output logic      [`WDT_DATA_W-1:0] count,
	output logic                        isZero
);

	logic [`WDT_DATA_W-1:0] count_q;
	logic [`WDT_DATA_W-1:0] count_d;

	always_comb begin
		count_d = count_q;
		if (load) begin
			count_d = loadVal;
		end else if (dec && (count_q != `WDT_ZERO)) begin
			count_d = count_q - 32'h00000001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			count_q <= `WDT_LOAD_RST;
		end else begin
			count_q <= count_d;
		end
	end

	assign count  = count_q;
	assign isZero = (count_q == `WDT_ZERO);

endmodule

// File: src/wdt_top.sv
// Purpose: Two-stage watchdog timer with register port
// Assumes: Single clock; debugHalt comes from core logic on core_clk
// Notes: System reset output is sticky until rst
//
// How it works
// - 32-bit down counter with programmable load
// - Lock blocks configuration register writes
// - First zero raises timeout interrupt status
// - Starting counter also enables interrupt
// - After first timeout, reload and continue
// - Second zero, pending, reset enabled: reset
// - Cleared before second zero: reload, no reset
// - Load write while running reloads counter
// - Locked: start, int enable, load ignored
// - Lock state readable, one means locked
// - Interrupt clear access drops the source
// - Raw and masked status both readable
// - Status reads one if active, else zero
// - Load register value reads back
// - Reset enable gates second-timeout reset
// - Load value zero raises interrupt at once
// - Debug stall holds counter when halted
// - Unlock restores configuration write access
`timescale 1ns/1ps
`include "wdt_params.svh"

module wdt_top (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	// Register port
	input  wire wdt_pkg::wdt_bus_req_t  busReq,
	output logic      [`WDT_DATA_W-1:0] rdData_q,
	// Debug state of the processor
	input  wire logic                   debugHalt,
	// To interrupt controller and system reset
	output logic                        irq_q,
	output logic                        sysReset_q
);

	function automatic logic hit(
		input logic [`WDT_ADDR_W-1:0] a,
		input logic [`WDT_ADDR_W-1:0] ofs
	);
		hit = (a == ofs);
	endfunction

	// Register state
	logic [`WDT_DATA_W-1:0] reload_q;
	logic [`WDT_DATA_W-1:0] reload_d;
	wdt_pkg::wdt_ctrl_t     ctrl_q;
	wdt_pkg::wdt_ctrl_t     ctrl_d;
	wdt_pkg::wdt_ctrl_t     ctrlWr;
	logic                   locked_q;
	logic                   locked_d;
	logic                   ris_q;
	logic                   ris_d;
	wdt_pkg::wdt_stage_t    stage_q;
	wdt_pkg::wdt_stage_t    stage_d;
	logic [`WDT_DATA_W-1:0] rdData_d;
	logic                   irq_d;
	logic                   sysReset_d;

	// Counter control
	logic                   cntLoad;
	logic [`WDT_DATA_W-1:0] cntLoadVal;
	logic                   tick;
	logic                   timeout;
	logic [`WDT_DATA_W-1:0] cntValue;
	logic                   cntZero;

	// Decoded accesses
	logic                   wrLoad;
	logic                   wrCtrl;
	logic                   wrIcr;
	logic                   wrLock;
	logic                   rawSet;
	logic                   rawClr;

	wdt_counter u_counter (
		.core_clk (core_clk),
		.rst      (rst),
		.load     (cntLoad),
		.loadVal  (cntLoadVal),
		.dec      (tick),
		.count    (cntValue),
		.isZero   (cntZero)
	);

	always_comb begin
		reload_d   = reload_q;
		ctrl_d     = ctrl_q;
		locked_d   = locked_q;
		stage_d    = stage_q;
		cntLoad    = 1'b0;
		cntLoadVal = reload_q;
		rawSet     = 1'b0;
		rawClr     = 1'b0;
		rdData_d   = `WDT_ZERO;
		ctrlWr     = busReq.wdata[`WDT_CTRL_W-1:0];

		// Config writes only land while unlocked
		wrLoad = busReq.wr && !locked_q && hit(busReq.addr, `WDT_OFS_LOAD);
		wrCtrl = busReq.wr && !locked_q && hit(busReq.addr, `WDT_OFS_CTRL);
		wrIcr  = busReq.wr && hit(busReq.addr, `WDT_OFS_ICR);
		wrLock = busReq.wr && hit(busReq.addr, `WDT_OFS_LOCK);

		// Once reset fires nothing counts until rst
		tick    = ctrl_q.enable && (stage_q != wdt_pkg::WDT_RST)
			&& !(ctrl_q.stallEn && debugHalt);
		timeout = tick && cntZero;

		// Key unlocks, any other value locks
		if (wrLock) begin
			locked_d = (busReq.wdata != `WDT_UNLOCK_KEY);
		end

		if (wrCtrl) begin
			// Enable and interrupt enable are set-only, as a hung task could otherwise stop the dog
			ctrl_d.enable  = ctrl_q.enable | ctrlWr.enable;
			ctrl_d.intEn   = ctrl_q.intEn | ctrlWr.intEn | ctrlWr.enable;
			ctrl_d.resetEn = ctrlWr.resetEn;
			ctrl_d.stallEn = ctrlWr.stallEn;
			if (!ctrl_q.enable && ctrlWr.enable) begin
				cntLoad = 1'b1;
			end
		end

		if (timeout) begin
			rawSet = 1'b1;
			if (ris_q && ctrl_q.resetEn) begin
				stage_d = wdt_pkg::WDT_RST;
			end else begin
				cntLoad = 1'b1;
			end
		end

		if (wrLoad) begin
			reload_d = busReq.wdata;
			if (ctrl_q.enable) begin
				cntLoad    = 1'b1;
				cntLoadVal = busReq.wdata;
			end
			if (busReq.wdata == `WDT_ZERO) begin
				rawSet = 1'b1;
			end
		end else if (cntLoad) begin
			cntLoadVal = reload_q;
		end

		if (wrIcr) begin
			rawClr = 1'b1;
		end

		// A timeout in the clearing cycle is kept
		ris_d = rawSet || (ris_q && !rawClr);

		if ((stage_q == wdt_pkg::WDT_IDLE) && ctrl_d.enable) begin
			stage_d = wdt_pkg::WDT_RUN;
		end

		irq_d      = ris_d && ctrl_d.intEn;
		sysReset_d = (stage_d == wdt_pkg::WDT_RST);

		if (busReq.rd) begin
			case (busReq.addr)
				`WDT_OFS_LOAD: begin
					rdData_d = reload_q;
				end
				`WDT_OFS_VALUE: begin
					rdData_d = cntValue;
				end
				`WDT_OFS_CTRL: begin
					rdData_d = {28'h0000000, ctrl_q};
				end
				`WDT_OFS_RIS: begin
					rdData_d = {31'h00000000, ris_q};
				end
				`WDT_OFS_MIS: begin
					rdData_d = {31'h00000000, ris_q && ctrl_q.intEn};
				end
				`WDT_OFS_LOCK: begin
					rdData_d = {31'h00000000, locked_q};
				end
				default: begin
					rdData_d = `WDT_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			reload_q   <= `WDT_LOAD_RST;
			ctrl_q     <= '0;
			locked_q   <= 1'b0;
			ris_q      <= 1'b0;
			stage_q    <= wdt_pkg::WDT_IDLE;
			rdData_q   <= `WDT_ZERO;
			irq_q      <= 1'b0;
			sysReset_q <= 1'b0;
		end else begin
			reload_q   <= reload_d;
			ctrl_q     <= ctrl_d;
			locked_q   <= locked_d;
			ris_q      <= ris_d;
			stage_q    <= stage_d;
			rdData_q   <= rdData_d;
			irq_q      <= irq_d;
			sysReset_q <= sysReset_d;
		end
	end

	property p_load_rb;
		@(posedge core_clk) disable iff (rst)
		wrLoad |=> (reload_q == $past(busReq.wdata));
	endproperty
	a_load_rb: assert property (p_load_rb) else $error("Load value not stored");

	property p_lock_load;
		@(posedge core_clk) disable iff (rst)
		(busReq.wr && locked_q && hit(busReq.addr, `WDT_OFS_LOAD)) |=> $stable(reload_q);
	endproperty
	a_lock_load: assert property (p_lock_load) else $error("Locked load write took effect");

	property p_lock_ctrl;
		@(posedge core_clk) disable iff (rst)
		(busReq.wr && locked_q && hit(busReq.addr, `WDT_OFS_CTRL)) |=> $stable(ctrl_q);
	endproperty
	a_lock_ctrl: assert property (p_lock_ctrl) else $error("Locked control write took effect");

	property p_start_int;
		@(posedge core_clk) disable iff (rst)
		(wrCtrl && ctrlWr.enable) |=> (ctrl_q.enable && ctrl_q.intEn);
	endproperty
	a_start_int: assert property (p_start_int) else $error("Start left interrupt disabled");

	property p_first;
		@(posedge core_clk) disable iff (rst)
		(timeout && !ris_q) |=> ris_q ##0 (irq_q == ctrl_q.intEn);
	endproperty
	a_first: assert property (p_first) else $error("First timeout not flagged");

	property p_reload;
		@(posedge core_clk) disable iff (rst)
		(timeout && !(ris_q && ctrl_q.resetEn) && !wrLoad) |=> (cntValue == $past(reload_q));
	endproperty
	a_reload: assert property (p_reload) else $error("Counter not reloaded after timeout");

	property p_second;
		@(posedge core_clk) disable iff (rst)
		(timeout && ris_q && ctrl_q.resetEn) |=> sysReset_q [*3];
	endproperty
	a_second: assert property (p_second) else $error("Second timeout did not reset");

	property p_no_reset;
		@(posedge core_clk) disable iff (rst)
		(!ctrl_q.resetEn && !sysReset_q) |=> !sysReset_q;
	endproperty
	a_no_reset: assert property (p_no_reset) else $error("Reset while reset disabled");

	property p_live_load;
		@(posedge core_clk) disable iff (rst)
		(wrLoad && ctrl_q.enable) |=> (cntValue == $past(busReq.wdata));
	endproperty
	a_live_load: assert property (p_live_load) else $error("Running counter not loaded");

	property p_clear;
		@(posedge core_clk) disable iff (rst)
		(wrIcr && !timeout && !(wrLoad && busReq.wdata == `WDT_ZERO)) |=> (!ris_q && !irq_q);
	endproperty
	a_clear: assert property (p_clear) else $error("Interrupt clear ignored");

	property p_sticky;
		@(posedge core_clk) disable iff (rst)
		(ris_q && !wrIcr) |=> ris_q;
	endproperty
	a_sticky: assert property (p_sticky) else $error("Raw status dropped without clear");

	property p_zero_load;
		@(posedge core_clk) disable iff (rst)
		(wrLoad && busReq.wdata == `WDT_ZERO) |=> ris_q;
	endproperty
	a_zero_load: assert property (p_zero_load) else $error("Zero load raised no interrupt");

	property p_stall;
		@(posedge core_clk) disable iff (rst)
		(ctrl_q.stallEn && debugHalt && !cntLoad) |=> $stable(cntValue);
	endproperty
	a_stall: assert property (p_stall) else $error("Counter moved during debug halt");

	property p_lock_rd;
		@(posedge core_clk) disable iff (rst)
		(busReq.rd && hit(busReq.addr, `WDT_OFS_LOCK)) |=> (rdData_q[0] == $past(locked_q));
	endproperty
	a_lock_rd: assert property (p_lock_rd) else $error("Lock state read wrong");

	property p_mis_rd;
		@(posedge core_clk) disable iff (rst)
		(busReq.rd && hit(busReq.addr, `WDT_OFS_MIS))
			|=> (rdData_q == {31'h00000000, $past(ris_q && ctrl_q.intEn)});
	endproperty
	a_mis_rd: assert property (p_mis_rd) else $error("Masked status read wrong");

	property p_unlock;
		@(posedge core_clk) disable iff (rst)
		(wrLock && busReq.wdata == `WDT_UNLOCK_KEY) |=> !locked_q;
	endproperty
	a_unlock: assert property (p_unlock) else $error("Unlock key did not unlock");

	property p_raw_rd;
		@(posedge core_clk) disable iff (rst)
		(busReq.rd && hit(busReq.addr, `WDT_OFS_RIS)) |=> (rdData_q == {31'h00000000, $past(ris_q)});
	endproperty
	a_raw_rd: assert property (p_raw_rd) else $error("Raw status read wrong");

	property p_rst_hold;
		@(posedge core_clk) disable iff (rst)
		sysReset_q |=> sysReset_q;
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("System reset dropped before rst");

	property p_cleared_run;
		@(posedge core_clk) disable iff (rst)
		(timeout && !ris_q && !sysReset_q) |=> !sysReset_q;
	endproperty
	a_cleared_run: assert property (p_cleared_run) else $error("Reset after a cleared timeout");

	property p_count;
		@(posedge core_clk) disable iff (rst)
		(ctrl_q.enable && !(ctrl_q.stallEn && debugHalt) && (stage_q != wdt_pkg::WDT_RST)
			&& !cntZero && !cntLoad) |=> (cntValue == $past(cntValue) - 32'h00000001);
	endproperty
	a_count: assert property (p_count) else $error("Counter did not step down");

	property p_lock_set;
		@(posedge core_clk) disable iff (rst)
		(wrLock && busReq.wdata != `WDT_UNLOCK_KEY) |=> locked_q;
	endproperty
	a_lock_set: assert property (p_lock_set) else $error("Lock write did not lock");

	property p_icr_locked;
		@(posedge core_clk) disable iff (rst)
		(busReq.wr && locked_q && hit(busReq.addr, `WDT_OFS_ICR) && !timeout) |=> !ris_q;
	endproperty
	a_icr_locked: assert property (p_icr_locked) else $error("Clear ignored while locked");

endmodule

// File: test/wdt_irq_partner.sv
// Purpose: Interrupt controller and system reset seen from the watchdog
// Assumes: Both lines are level outputs on core_clk
// Notes: Only records what arrives; the bench services the interrupt
`timescale 1ns/1ps

module wdt_irq_partner (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Lines from the watchdog
	input  wire logic       irq_q,
	input  wire logic       sysReset_q,
	// What the controller saw
	output logic [7:0]      irqRises,
	output logic            resetSeen
);
	logic irqLast_q;

	// A level held across a handler return would count once only, as a real controller sees it
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irqLast_q <= 1'b0;
			irqRises  <= 8'h00;
			resetSeen <= 1'b0;
		end else begin
			irqLast_q <= irq_q;
			if (irq_q && !irqLast_q)
				irqRises <= irqRises + 8'h01;
			if (sysReset_q)
				resetSeen <= 1'b1;
		end
	end
endmodule

// File: test/wdt_top_bench.sv
// Purpose: Self-checking bench for the watchdog register port and outputs
// Assumes: Requests driven right after a rising edge, one idle cycle between them
// Notes: Counts kept short by small load values
`timescale 1ns/1ps
`include "wdt_params.svh"

module wdt_top_bench;
	logic                   core_clk = 1'b0;
	logic                   rst = 1'b1;
	wdt_pkg::wdt_bus_req_t  busReq = '0;
	logic                   debugHalt = 1'b0;
	logic [`WDT_DATA_W-1:0] rdData_q;
	logic                   irq_q;
	logic                   sysReset_q;
	logic [7:0]             irqRises;
	logic                   resetSeen;
	logic [`WDT_DATA_W-1:0] v0;
	logic [`WDT_DATA_W-1:0] v1;
	int                     failCount = 0;
	int                     checksDone = 0;
	int                     n;

	always #5 core_clk = ~core_clk;

	wdt_top DUT (.core_clk(core_clk), .rst(rst), .busReq(busReq), .rdData_q(rdData_q),
		.debugHalt(debugHalt), .irq_q(irq_q), .sysReset_q(sysReset_q));

	wdt_irq_partner PARTNER (.core_clk(core_clk), .rst(rst), .irq_q(irq_q), .sysReset_q(sysReset_q),
		.irqRises(irqRises), .resetSeen(resetSeen));

	task automatic completeRun();
		$display("checks %0d, mismatches %0d", checksDone, failCount);
		if (failCount == 0 && checksDone > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checksDone++;
		if (got !== exp) begin
			failCount++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// The idle cycle after each strobe keeps one assignment per signal per time step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge core_clk);
		busReq <= '0;
		@(posedge core_clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge core_clk);
		busReq <= '0;
		#1 d = rdData_q;
		@(posedge core_clk);
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] d;
		rd(a, d);
		check(d, exp, what);
	endtask

	task automatic waitFor(input bit useReset, input logic lvl, input int maxCyc, output int cyc);
		cyc = 0;
		@(negedge core_clk);
		while ((useReset ? sysReset_q : irq_q) !== lvl && cyc < maxCyc) begin
			@(negedge core_clk);
			cyc++;
		end
		if (cyc >= maxCyc) begin
			failCount++;
			$display("wrong value at %0t: output never reached its level", $time);
			completeRun();
		end else begin
			@(posedge core_clk);
		end
	endtask

	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		rdChk(`WDT_OFS_LOAD, 32'hffffffff, "load reset");
		rdChk(`WDT_OFS_VALUE, 32'hffffffff, "count reset");
		rdChk(`WDT_OFS_CTRL, 32'h0, "ctrl reset");
		rdChk(`WDT_OFS_RIS, 32'h0, "raw reset");
		rdChk(`WDT_OFS_LOCK, 32'h0, "lock reset");
		rdChk(8'h1c, 32'h0, "unmapped");
		wr(`WDT_OFS_LOAD, 32'h0);
		rdChk(`WDT_OFS_RIS, 32'h1, "zero load raw");
		rdChk(`WDT_OFS_MIS, 32'h0, "masked off");
		check(irq_q, 1'b0, "irq masked");
		wr(`WDT_OFS_ICR, 32'h0);
		rdChk(`WDT_OFS_RIS, 32'h0, "raw cleared");
		wr(`WDT_OFS_LOCK, 32'h0);
		rdChk(`WDT_OFS_LOCK, 32'h1, "locked");
		wr(`WDT_OFS_LOAD, 32'h37);
		wr(`WDT_OFS_CTRL, 32'hf);
		rdChk(`WDT_OFS_LOAD, 32'h0, "locked load");
		rdChk(`WDT_OFS_CTRL, 32'h0, "locked ctrl");
		wr(`WDT_OFS_LOCK, `WDT_UNLOCK_KEY);
		rdChk(`WDT_OFS_LOCK, 32'h0, "unlocked");
		wr(`WDT_OFS_LOAD, 32'h64);
		rdChk(`WDT_OFS_LOAD, 32'h64, "load after unlock");
		debugHalt <= 1'b1;
		wr(`WDT_OFS_CTRL, 32'h9);
		rd(`WDT_OFS_VALUE, v0);
		check(v0, 32'h64, "started from load");
		repeat (10) @(posedge core_clk);
		rd(`WDT_OFS_VALUE, v1);
		check(v1, v0, "stalled");
		// Halt stays high: with stalling off the count must still move, and reset is armed early
		wr(`WDT_OFS_CTRL, 32'h5);
		rd(`WDT_OFS_VALUE, v0);
		check(v0 < 32'h64, 1'b1, "runs unstalled");
		debugHalt <= 1'b0;
		// Counter near 97 here, so only the new value can time out this soon
		wr(`WDT_OFS_LOAD, 32'h14);
		waitFor(1'b0, 1'b1, 40, n);
		check(n >= 18 && n <= 25, 1'b1, "first timeout time");
		rdChk(`WDT_OFS_CTRL, 32'h7, "enable sets int");
		rdChk(`WDT_OFS_RIS, 32'h1, "raw set");
		rdChk(`WDT_OFS_MIS, 32'h1, "masked set");
		check(sysReset_q, 1'b0, "first timeout no reset");
		rd(`WDT_OFS_VALUE, v0);
		check(v0 <= 32'h14, 1'b1, "reloaded");
		repeat (5) @(posedge core_clk);
		rdChk(`WDT_OFS_RIS, 32'h1, "raw sticky");
		wr(`WDT_OFS_ICR, 32'h1);
		waitFor(1'b0, 1'b0, 3, n);
		rdChk(`WDT_OFS_MIS, 32'h0, "masked cleared");
		waitFor(1'b0, 1'b1, 30, n);
		check(sysReset_q, 1'b0, "no reset after clear");
		wr(`WDT_OFS_CTRL, 32'h1);
		repeat (30) @(posedge core_clk);
		check(sysReset_q, 1'b0, "reset disabled");
		wr(`WDT_OFS_CTRL, 32'h4);
		waitFor(1'b1, 1'b1, 30, n);
		// Partner registers land on the edge, so look once they have settled
		@(negedge core_clk);
		check(irqRises, 8'h02, "irq count");
		check(resetSeen, 1'b1, "reset seen");
		@(posedge core_clk);
		check(sysReset_q, 1'b1, "reset sticky");
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		check(sysReset_q, 1'b0, "reset cleared by rst");
		rdChk(`WDT_OFS_VALUE, 32'hffffffff, "count after rst");
		rdChk(`WDT_OFS_RIS, 32'h0, "raw after rst");
		completeRun();
	end
endmodule
